// ===== src/fltc_elastic_store.sv
// dual clock elastic store with gray pointers, flop storage
`timescale 1ns/1ps
module fltc_elastic_store
  import fltc_pkg::*;
(
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic wr_en,
  input wire logic [ES_W-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  input wire logic rd_en,
  output logic [ES_W-1:0] rd_data,
  output logic full,
  output logic empty
);

  logic [ES_W-1:0] mem_q [ES_DEPTH]; // storage, written on wr_clk
  logic [ES_AW:0] wbin_q; // write pointer, binary
  logic [ES_AW:0] wgray_q; // write pointer, gray
  logic [ES_AW:0] rbin_q; // read pointer, binary
  logic [ES_AW:0] rgray_q; // read pointer, gray
  logic [ES_AW:0] rgray_w; // read pointer seen in write domain
  logic [ES_AW:0] wgray_r; // write pointer seen in read domain
  logic [ES_AW:0] wbin_d; // next write pointer
  logic [ES_AW:0] rbin_d; // next read pointer

  ////////////////////////////////////////////////////////////////////////
  // pointer crossings
  fltc_sync #(.W(ES_AW + 1)) u_rptr_sync
  (
    .clk(wr_clk),
    .rst_n(wr_rst_n),
    .d(rgray_q),
    .q(rgray_w)
  );

  fltc_sync #(.W(ES_AW + 1)) u_wptr_sync
  (
    .clk(rd_clk),
    .rst_n(rd_rst_n),
    .d(wgray_q),
    .q(wgray_r)
  );

  // full when top two gray bits differ and the rest match
  assign full = (wgray_q == {~rgray_w[ES_AW:ES_AW-1], rgray_w[ES_AW-2:0]});
  assign empty = (rgray_q == wgray_r);
  assign wbin_d = wbin_q + (ES_AW + 1)'(wr_en && !full);
  assign rbin_d = rbin_q + (ES_AW + 1)'(rd_en && !empty);

  ////////////////////////////////////////////////////////////////////////
  // write side: entries beyond a full store are dropped (slip)
  always_ff @(posedge wr_clk or negedge wr_rst_n)
  begin
    if (!wr_rst_n)
    begin
      wbin_q <= '0;
      wgray_q <= '0;
    end
    else
    begin
      wbin_q <= wbin_d;
      wgray_q <= wbin_d ^ (wbin_d >> 1);
    end
  end

  // storage written only while not full
  always_ff @(posedge wr_clk)
  begin
    if (wr_en && !full)
    begin
      mem_q[wbin_q[ES_AW-1:0]] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read side: an empty store gives zeros (underrun)
  always_ff @(posedge rd_clk or negedge rd_rst_n)
  begin
    if (!rd_rst_n)
    begin
      rbin_q <= '0;
      rgray_q <= '0;
      rd_data <= ES_WORD_RESET;
    end
    else
    begin
      rbin_q <= rbin_d;
      rgray_q <= rbin_d ^ (rbin_d >> 1);
      if (rd_en && !empty)
      begin
        rd_data <= mem_q[rbin_q[ES_AW-1:0]];
      end
      else
      begin
        rd_data <= ES_WORD_RESET;
      end
    end
  end

endmodule

// ===== src/fltc_pkg.sv
// shared constants for the line and tdm port clocking block
package fltc_pkg;

  // elastic store geometry: one data bit plus one sync bit per entry
  localparam int ES_W = 2;
  localparam int ES_AW = 3;
  localparam int ES_DEPTH = 8;

  // field positions inside a store entry
  localparam int ES_DATA_BIT = 0;
  localparam int ES_SYNC_BIT = 1;

  // reset value of every configuration and data flop except the store entries
  localparam logic CFG_RESET = 1'h0;
  localparam logic [ES_W-1:0] ES_WORD_RESET = 2'h0;

  // transmit system clock rate select encoding
  localparam logic RATE_SEL_T1 = 1'h0;
  localparam logic RATE_SEL_E1 = 1'h1;

  // frame bit counter: last bit index per rate (193 and 256 bits)
  localparam int FRAME_CNT_W = 9;
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST_T1 = 9'h0C0;
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST_E1 = 9'h0FF;
  localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_RESET = 9'h000;

endpackage

// ===== src/fltc_port_clocking.sv
// line side and tdm side clock and data pins of one framer port
//
// Summary of operation
// - line clock follows rx clock in loopback
// - line unit disabled: clock, data face outside
// - line unit enabled: tx line data low
// - tx line data changes on line clock rise
// - rx invert bit inverts rx framer clock
// - line unit enabled: rx pin outputs recovered clock
// - no rx store: outputs change on rx rise
// - rx store: write rx rise, read sysclk rise
// - line unit enabled: rx line data ignored
// - rx line data sampled on rx fall
// - no tx store: inputs sampled on tx fall
// - tx store: write sysclk fall, read tx fall
// - tx invert bit inverts formatter clock
// - rate select sets tx system clock rate
// - reference clock may clock tx, rx too
// - tx clocks active only in external mode
// - internal mode holds rx serial data low
`timescale 1ns/1ps
module fltc_port_clocking
  import fltc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic EXTERNAL_MODE,
  input wire logic INTERNAL_LINE_UNIT_DISABLE,
  input wire logic FRAMER_LOOPBACK,
  input wire logic PAYLOAD_LOOPBACK,
  input wire logic TX_NRZ_OUTPUT_SELECT,
  input wire logic RX_NRZ_INPUT_SELECT,
  input wire logic RX_CLOCK_INVERT,
  input wire logic TX_CLOCK_INVERT,
  input wire logic RX_ELASTIC_STORE_ENABLE,
  input wire logic TX_ELASTIC_STORE_ENABLE,
  input wire logic TX_SYSTEM_CLOCK_RATE_SELECT,
  input wire logic CLOCK_SOURCE_MODE,
  input wire logic USE_REFERENCE_CLOCK,
  input wire logic RX_FRAMER_CLOCK_IN,
  output logic RX_RECOVERED_CLOCK_OUT,
  output logic RX_CLOCK_PIN_OE,
  input wire logic LINE_UNIT_RECOVERED_CLOCK,
  input wire logic RX_LINE_DATA_IN,
  input wire logic FORMATTER_TX_CLOCK,
  input wire logic TX_SYSTEM_CLOCK,
  input wire logic RX_SYSTEM_CLOCK,
  input wire logic EXTERNAL_REFERENCE_CLOCK,
  output logic TX_LINE_CLOCK_OUT,
  output logic TX_LINE_DATA_OUT,
  output logic RX_SERIAL_DATA,
  output logic RX_SYNC,
  output logic RX_FRAME_SYNC,
  input wire logic TX_SERIAL_DATA,
  input wire logic TX_SYNC,
  output logic RX_LINE_BIT,
  output logic RX_NRZ_MODE,
  input wire logic FRAMER_RX_DATA,
  input wire logic FRAMER_RX_SYNC,
  input wire logic FRAMER_RX_FRAME_SYNC,
  output logic FORMATTER_TX_DATA,
  output logic FORMATTER_TX_SYNC,
  output logic TX_NRZ_MODE,
  input wire logic FORMATTER_LINE_BIT
);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers on CLK, stable sources for the crossings
  logic ext_q; // external mode
  logic internal_line_unit_disable_q; // internal line unit disabled
  logic loop_q; // framer or payload loopback
  logic rx_inv_q; // rx framer clock invert
  logic tx_inv_q; // formatter clock invert
  logic rx_es_q; // rx elastic store enable
  logic tx_es_q; // tx elastic store enable
  logic rate_q; // tx system clock rate
  logic ref_tx_q; // reference clock drives tx
  logic ref_rx_q; // reference clock drives rx
  logic rx_nrz_q; // framer accepts nrz
  logic tx_nrz_q; // formatter emits nrz

  // configuration capture
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ext_q <= CFG_RESET;
      internal_line_unit_disable_q <= CFG_RESET;
      loop_q <= CFG_RESET;
      rx_inv_q <= CFG_RESET;
      tx_inv_q <= CFG_RESET;
      rx_es_q <= CFG_RESET;
      tx_es_q <= CFG_RESET;
      rate_q <= CFG_RESET;
      ref_tx_q <= CFG_RESET;
      ref_rx_q <= CFG_RESET;
      rx_nrz_q <= CFG_RESET;
      tx_nrz_q <= CFG_RESET;
    end
    else
    begin
      ext_q <= EXTERNAL_MODE;
      internal_line_unit_disable_q <= INTERNAL_LINE_UNIT_DISABLE;
      loop_q <= FRAMER_LOOPBACK | PAYLOAD_LOOPBACK;
      rx_inv_q <= RX_CLOCK_INVERT;
      tx_inv_q <= TX_CLOCK_INVERT;
      rx_es_q <= RX_ELASTIC_STORE_ENABLE;
      tx_es_q <= TX_ELASTIC_STORE_ENABLE;
      rate_q <= TX_SYSTEM_CLOCK_RATE_SELECT;
      ref_tx_q <= USE_REFERENCE_CLOCK;
      // reference clocks rx only in one-clock mode
      ref_rx_q <= USE_REFERENCE_CLOCK & ~CLOCK_SOURCE_MODE;
      rx_nrz_q <= RX_NRZ_INPUT_SELECT;
      tx_nrz_q <= TX_NRZ_OUTPUT_SELECT;
    end
  end

  // nrz selects are handed to the framer and formatter
  assign RX_NRZ_MODE = rx_nrz_q;
  assign TX_NRZ_MODE = tx_nrz_q;

  ////////////////////////////////////////////////////////////////////////
  // clock selection; selects are quasi-static, change only when idle
  logic rx_clk; // effective rx framer clock
  logic tx_clk; // effective formatter clock
  logic rx_sys_clk; // gated rx system clock
  logic tx_sys_clk; // gated tx system clock
  logic tx_line_clk; // clock behind the tx line clock pin
  logic tx_clk_n; // falling-edge view of formatter clock
  logic tx_sys_clk_n; // falling-edge view of tx system clock

  // rx: reference, outside pin (optionally inverted) or recovered
  assign rx_clk = ref_rx_q ? EXTERNAL_REFERENCE_CLOCK :
    internal_line_unit_disable_q ? (RX_FRAMER_CLOCK_IN ^ rx_inv_q) :
    LINE_UNIT_RECOVERED_CLOCK;

  // tx clocks are held low outside external mode
  assign tx_clk = ext_q & (ref_tx_q ? EXTERNAL_REFERENCE_CLOCK :
    (FORMATTER_TX_CLOCK ^ tx_inv_q));
  assign tx_sys_clk = ext_q & TX_SYSTEM_CLOCK;
  assign rx_sys_clk = ext_q & RX_SYSTEM_CLOCK;
  assign tx_clk_n = ~tx_clk;
  assign tx_sys_clk_n = ~tx_sys_clk;

  // line clock follows rx clock in either loopback
  assign tx_line_clk = loop_q ? rx_clk : tx_clk;
  assign TX_LINE_CLOCK_OUT = tx_line_clk;

  // shared rx clock pin drives recovered clock while line unit is used
  assign RX_CLOCK_PIN_OE = ~internal_line_unit_disable_q;
  assign RX_RECOVERED_CLOCK_OUT = LINE_UNIT_RECOVERED_CLOCK & ~internal_line_unit_disable_q;

  ////////////////////////////////////////////////////////////////////////
  // configuration crossings into each link domain
  logic rx_internal_line_unit_disable_s; // line unit disable, rx domain
  logic rx_es_w; // rx store enable, rx domain
  logic rx_es_r; // rx store enable, rx system domain
  logic tx_es_s; // tx store enable, formatter domain
  logic tx_es_w; // tx store enable, tx system domain
  logic tx_rate_s; // rate select, tx system domain

  fltc_sync #(.W(2)) u_rx_cfg_sync
  (
    .clk(rx_clk),
    .rst_n(RESETN),
    .d({internal_line_unit_disable_q, rx_es_q}),
    .q({rx_internal_line_unit_disable_s, rx_es_w})
  );

  fltc_sync #(.W(1)) u_rsys_cfg_sync
  (
    .clk(rx_sys_clk),
    .rst_n(RESETN),
    .d(rx_es_q),
    .q(rx_es_r)
  );

  fltc_sync #(.W(1)) u_tx_cfg_sync
  (
    .clk(tx_clk_n),
    .rst_n(RESETN),
    .d(tx_es_q),
    .q(tx_es_s)
  );

  fltc_sync #(.W(2)) u_tsys_cfg_sync
  (
    .clk(tx_sys_clk_n),
    .rst_n(RESETN),
    .d({tx_es_q, rate_q}),
    .q({tx_es_w, tx_rate_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // rx line data sampled on falling rx clock, zero while ignored
  always_ff @(negedge rx_clk or negedge RESETN)
  begin
    if (!RESETN)
    begin
      RX_LINE_BIT <= CFG_RESET;
    end
    else if (rx_internal_line_unit_disable_s)
    begin
      RX_LINE_BIT <= RX_LINE_DATA_IN;
    end
    else
    begin
      RX_LINE_BIT <= CFG_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rx direct path: framer outputs registered on rising rx clock
  logic rx_ser_q; // direct serial data
  logic rx_sync_q; // direct sync
  logic rx_fsync_q; // direct frame or multiframe sync
  logic [ES_W-1:0] rx_es_rd; // rx store read word
  logic rx_fs_sys_q; // frame sync on system side
  logic rx_es_full; // rx store full
  logic rx_es_empty; // rx store empty

  // register framer outputs for the cross-connect side
  always_ff @(posedge rx_clk or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_ser_q <= CFG_RESET;
      rx_sync_q <= CFG_RESET;
      rx_fsync_q <= CFG_RESET;
    end
    else
    begin
      rx_ser_q <= FRAMER_RX_DATA;
      rx_sync_q <= FRAMER_RX_SYNC;
      rx_fsync_q <= FRAMER_RX_FRAME_SYNC;
    end
  end

  // rx store: written on rising rx clock, read on rising system clock
  fltc_elastic_store u_rx_store
  (
    .wr_clk(rx_clk),
    .wr_rst_n(RESETN),
    .wr_en(rx_es_w),
    .wr_data({FRAMER_RX_SYNC, FRAMER_RX_DATA}),
    .rd_clk(rx_sys_clk),
    .rd_rst_n(RESETN),
    .rd_en(rx_es_r),
    .rd_data(rx_es_rd),
    .full(rx_es_full),
    .empty(rx_es_empty)
  );

  // frame sync on the system side repeats the read sync bit
  always_ff @(posedge rx_sys_clk or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_fs_sys_q <= CFG_RESET;
    end
    else
    begin
      rx_fs_sys_q <= rx_es_rd[ES_SYNC_BIT];
    end
  end

  // output select; internal mode holds the serial data low
  always_comb
  begin
    if (!ext_q)
    begin
      RX_SERIAL_DATA = 1'h0;
      RX_SYNC = 1'h0;
      RX_FRAME_SYNC = 1'h0;
    end
    else if (rx_es_q)
    begin
      RX_SERIAL_DATA = rx_es_rd[ES_DATA_BIT];
      RX_SYNC = rx_es_rd[ES_SYNC_BIT];
      RX_FRAME_SYNC = rx_fs_sys_q;
    end
    else
    begin
      RX_SERIAL_DATA = rx_ser_q;
      RX_SYNC = rx_sync_q;
      RX_FRAME_SYNC = rx_fsync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tx system side: frame counter at the selected rate, realigned by sync
  logic [FRAME_CNT_W-1:0] tfrm_q; // bit position within frame
  logic [FRAME_CNT_W-1:0] tfrm_last; // last bit index for rate
  logic tfrm_wrap; // frame boundary from the counter
  logic [ES_W-1:0] tx_es_rd; // tx store read word
  logic tx_es_full; // tx store full
  logic tx_es_empty; // tx store empty

  assign tfrm_last = (tx_rate_s == RATE_SEL_E1) ? FRAME_LAST_E1 :
    FRAME_LAST_T1;
  assign tfrm_wrap = (tfrm_q == tfrm_last);

  // counter runs on falling system clock
  always_ff @(negedge tx_sys_clk or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tfrm_q <= FRAME_CNT_RESET;
    end
    else if (TX_SYNC || tfrm_wrap)
    begin
      tfrm_q <= FRAME_CNT_RESET;
    end
    else
    begin
      tfrm_q <= tfrm_q + 9'h001;
    end
  end

  // tx store: written on falling system clock, read on falling tx clock
  fltc_elastic_store u_tx_store
  (
    .wr_clk(tx_sys_clk_n),
    .wr_rst_n(RESETN),
    .wr_en(tx_es_w),
    .wr_data({TX_SYNC | tfrm_wrap, TX_SERIAL_DATA}),
    .rd_clk(tx_clk_n),
    .rd_rst_n(RESETN),
    .rd_en(tx_es_s),
    .rd_data(tx_es_rd),
    .full(tx_es_full),
    .empty(tx_es_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // formatter inputs on falling tx clock, direct or from the store
  always_ff @(negedge tx_clk or negedge RESETN)
  begin
    if (!RESETN)
    begin
      FORMATTER_TX_DATA <= CFG_RESET;
      FORMATTER_TX_SYNC <= CFG_RESET;
    end
    else if (tx_es_s)
    begin
      FORMATTER_TX_DATA <= tx_es_rd[ES_DATA_BIT];
      FORMATTER_TX_SYNC <= tx_es_rd[ES_SYNC_BIT];
    end
    else
    begin
      FORMATTER_TX_DATA <= TX_SERIAL_DATA;
      FORMATTER_TX_SYNC <= TX_SYNC;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tx line data updated on rising line clock, low while line unit used
  logic tx_line_q; // registered line bit

  always_ff @(posedge tx_line_clk or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_line_q <= CFG_RESET;
    end
    else
    begin
      tx_line_q <= FORMATTER_LINE_BIT;
    end
  end

  assign TX_LINE_DATA_OUT = tx_line_q & internal_line_unit_disable_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_loop_clock_sel: assert property (
    @(posedge CLK) disable iff (!RESETN)
    loop_q |-> (TX_LINE_CLOCK_OUT == rx_clk))
    else $error("line clock not following rx clock in loopback");

  a_line_data_low: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !internal_line_unit_disable_q |-> !TX_LINE_DATA_OUT)
    else $error("tx line data driven while line unit in use");

  a_line_data_edge: assert property (
    @(posedge tx_line_clk) disable iff (!RESETN)
    internal_line_unit_disable_q ##1 internal_line_unit_disable_q |-> TX_LINE_DATA_OUT == $past(FORMATTER_LINE_BIT))
    else $error("tx line data not taken on line clock rise");

  a_rx_clk_invert: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (internal_line_unit_disable_q && rx_inv_q && !ref_rx_q) |-> rx_clk == !RX_FRAMER_CLOCK_IN)
    else $error("rx framer clock not inverted");

  a_rx_pin_output: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !internal_line_unit_disable_q |-> RX_CLOCK_PIN_OE &&
      (RX_RECOVERED_CLOCK_OUT == LINE_UNIT_RECOVERED_CLOCK))
    else $error("shared rx clock pin not driven");

  a_rx_direct_out: assert property (
    @(posedge rx_clk) disable iff (!RESETN)
    (ext_q && !rx_es_q) [*2] |-> RX_SERIAL_DATA == $past(FRAMER_RX_DATA))
    else $error("rx serial data not from framer on rx rise");

  a_rx_line_ignore: assert property (
    @(negedge rx_clk) disable iff (!RESETN)
    !rx_internal_line_unit_disable_s |=> !RX_LINE_BIT)
    else $error("rx line data accepted while ignored");

  a_tx_direct_in: assert property (
    @(negedge tx_clk) disable iff (!RESETN)
    !tx_es_s |=> FORMATTER_TX_DATA == $past(TX_SERIAL_DATA)
      && FORMATTER_TX_SYNC == $past(TX_SYNC))
    else $error("tx inputs not sampled on formatter fall");

  a_tx_clk_gated: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !ext_q |-> !tx_clk && !tx_sys_clk)
    else $error("tx clocks active outside external mode");

  a_rx_ser_low: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !ext_q |-> !RX_SERIAL_DATA && !RX_SYNC)
    else $error("rx serial data not held low in internal mode");

endmodule

// ===== src/fltc_sync.sv
// two flip-flop level synchroniser, parameterised width
`timescale 1ns/1ps
module fltc_sync
  import fltc_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q; // first stage, read only by the second

  ////////////////////////////////////////////////////////////////////////
  // two stages on the destination clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ===== test/fltc_line_partner.sv
// behavioural external line device: rx clock, line data, tx clock
`timescale 1ns/1ps
module fltc_line_partner
(
  input wire logic run,
  output logic rclk,
  output logic tclk,
  output logic rdata
);
  ////////////////////////////////////////////////////////////////////
  // 80 ns line clock, parks low while run is low
  initial
  begin
    rclk = 1'h0;
    tclk = 1'h0;
    rdata = 1'h0;
    #13;
    forever
    begin
      #40;
      if (run || rclk)
        rclk = ~rclk;
      else
        rdata = ~rdata; // idle line shows no stale bit
    end
  end
  // nrz bit moves a quarter period after the rise, steady at both clock edges
  always @(posedge rclk)
    rdata <= #20 1'($urandom);
  // formatter clock lags the line clock by a quarter period
  always @(rclk)
    tclk <= #20 rclk;
endmodule

// ===== test/fltc_port_clocking_bench.sv
// self-checking bench for the port clocking block
`timescale 1ns/1ps
module fltc_port_clocking_bench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ext, lud, framer_loopback, payload_loopback, rinv, tinv, uref, rate, tnrz, rnrz;
  logic res, tes, one_clk; // store enables, reference clock on rx too
  logic run, fr_d, fr_s, fr_fs, ts_d, ts_s, fl_bit;
  logic p_rclk, p_tclk, p_rdata;
  logic rec_out, pin_oe, tl_clk, tl_dat, rs_d, rs_s, rs_fs;
  logic rl_bit, r_nrz, t_nrz, fx_d, fx_s;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  // shared pin level and the clocks the block uses inside
  wire pin = pin_oe ? rec_out : p_rclk;
  wire ref_clk = ~p_tclk;
  wire rx_int = (uref & one_clk) ? ref_clk : lud ? pin ^ rinv : p_rclk;
  wire tx_int = uref ? ref_clk : p_tclk ^ tinv;
  // config words: ext lud flb plb rinv tinv uref rate tnrz rnrz
  logic [9:0] fixed_cfg [8] = '{10'h200, 10'h303, 10'h323, 10'h313,
    10'h383, 10'h343, 10'h30B, 10'h107};

  always #20 clk = ~clk;

  fltc_line_partner partner (.run(run), .rclk(p_rclk), .tclk(p_tclk),
    .rdata(p_rdata));

  fltc_port_clocking uut (
    .CLK(clk),
    .RESETN(rst_n),
    .EXTERNAL_MODE(ext),
    .INTERNAL_LINE_UNIT_DISABLE(lud),
    .FRAMER_LOOPBACK(framer_loopback),
    .PAYLOAD_LOOPBACK(payload_loopback),
    .TX_NRZ_OUTPUT_SELECT(tnrz),
    .RX_NRZ_INPUT_SELECT(rnrz),
    .RX_CLOCK_INVERT(rinv),
    .TX_CLOCK_INVERT(tinv),
    .RX_ELASTIC_STORE_ENABLE(res),
    .TX_ELASTIC_STORE_ENABLE(tes),
    .TX_SYSTEM_CLOCK_RATE_SELECT(rate),
    .CLOCK_SOURCE_MODE(~one_clk),
    .USE_REFERENCE_CLOCK(uref),
    .RX_FRAMER_CLOCK_IN(pin),
    .RX_RECOVERED_CLOCK_OUT(rec_out),
    .RX_CLOCK_PIN_OE(pin_oe),
    .LINE_UNIT_RECOVERED_CLOCK(p_rclk),
    .RX_LINE_DATA_IN(p_rdata),
    .FORMATTER_TX_CLOCK(p_tclk),
    .TX_SYSTEM_CLOCK(tes ? ~p_rclk : 1'h0),
    .RX_SYSTEM_CLOCK(res ? p_tclk : 1'h0),
    .EXTERNAL_REFERENCE_CLOCK(ref_clk),
    .TX_LINE_CLOCK_OUT(tl_clk),
    .TX_LINE_DATA_OUT(tl_dat),
    .RX_SERIAL_DATA(rs_d),
    .RX_SYNC(rs_s),
    .RX_FRAME_SYNC(rs_fs),
    .TX_SERIAL_DATA(ts_d),
    .TX_SYNC(ts_s),
    .RX_LINE_BIT(rl_bit),
    .RX_NRZ_MODE(r_nrz),
    .FRAMER_RX_DATA(fr_d),
    .FRAMER_RX_SYNC(fr_s),
    .FRAMER_RX_FRAME_SYNC(fr_fs),
    .FORMATTER_TX_DATA(fx_d),
    .FORMATTER_TX_SYNC(fx_s),
    .TX_NRZ_MODE(t_nrz),
    .FORMATTER_LINE_BIT(fl_bit)
  );

  ////////////////////////////////////////////////////////////////////
  // random stream inputs, moved a quarter period after their clock edges
  // with a store on: toggling data and steady sync show the order
  always @(posedge rx_int)
    #20 {fr_d, fr_s, fr_fs} = res ? {~fr_d, 2'h3} : 3'($urandom);
  always @(posedge tx_int)
    #20 {ts_d, ts_s} = tes ? {~ts_d, 1'h0} : 2'($urandom);
  always @(negedge tl_clk)
    #20 fl_bit = 1'($urandom);

  // compare and count
  task automatic check(input logic seen, input logic exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      err_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // config only changes while the line clocks stand still
  // upper bits: rx store, tx store, reference clock on rx as well
  task automatic set_cfg(input logic [12:0] v);
    run = 1'h0;
    repeat (4) @(posedge clk);
    #2;
    {res, tes, one_clk, ext, lud, framer_loopback, payload_loopback, rinv, tinv, uref, rate, tnrz,
      rnrz} = v;
    repeat (4) @(posedge clk);
    #2;
    run = 1'h1;
    repeat (3) @(posedge p_rclk);
  endtask

  // line clock source, inverted clocks included
  task automatic line_clk_chk();
    check(tl_clk, (framer_loopback | payload_loopback) ? rx_int : (ext & tx_int));
  endtask

  // receive side: direct outputs on rise, line bit on fall
  task automatic rx_loop();
    logic d, s, f, b;
    repeat (10)
    begin
      @(posedge rx_int);
      {d, s, f} = {fr_d, fr_s, fr_fs};
      #5;
      if (!res)
      begin
        check(rs_d, d & ext);
        check(rs_s, s & ext);
        check(rs_fs, f & ext);
      end
      check(rec_out, p_rclk & ~lud);
      line_clk_chk();
      @(negedge rx_int);
      b = p_rdata;
      #5;
      check(rl_bit, b & lud);
      check(pin_oe, ~lud);
      line_clk_chk();
    end
  endtask

  // formatter inputs taken on falling tx clock
  task automatic tx_loop();
    logic d, s;
    repeat (10)
    begin
      @(negedge tx_int);
      {d, s} = {ts_d, ts_s};
      #5;
      check(fx_d, d);
      check(fx_s, s);
    end
  endtask

  // line data launched on rising line clock
  task automatic line_loop();
    logic b;
    repeat (10)
    begin
      @(posedge tl_clk);
      b = fl_bit;
      #5;
      check(tl_dat, b & lud);
    end
  endtask

  // rx store: toggling data comes out in order on system clock rise
  task automatic rx_store_loop();
    logic prev;
    repeat (8) @(posedge p_tclk);
    #5;
    prev = rs_d;
    repeat (10)
    begin
      @(posedge p_tclk);
      #5;
      check(rs_d, ~prev);
      check(rs_s, 1'h1);
      check(rs_fs, 1'h1);
      prev = rs_d;
    end
  endtask

  // frame length in system clock bits for a rate select value
  function automatic int frame_len(input logic r);
    return r ? 256 : 193;
  endfunction

  // tx store: data in order, frame marks exactly one frame apart
  task automatic tx_store_loop();
    logic prev;
    int gap;
    int marks;
    gap = 0;
    marks = 0;
    repeat (8) @(negedge tx_int);
    #5;
    prev = fx_d;
    repeat (600)
    begin
      @(negedge tx_int);
      #5;
      check(fx_d, ~prev);
      prev = fx_d;
      gap++;
      if (fx_s)
      begin
        if (marks > 0)
          check(gap == frame_len(rate), 1'h1);
        marks++;
        gap = 0;
      end
    end
    check(marks > 1, 1'h1);
  endtask

  task automatic scen(input logic [12:0] v);
    set_cfg(v);
    fork
      rx_loop();
      if (ext && res) rx_store_loop();
      if (ext && !tes) tx_loop();
      if (ext && tes) tx_store_loop();
      if (ext) line_loop();
    join
    check(r_nrz, rnrz);
    check(t_nrz, tnrz);
    $display("test done cfg=%h", v);
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence: reset, fixed corners, random configs, then store and reference runs
  initial
  begin
    {ext, lud, framer_loopback, payload_loopback, rinv, tinv, uref, rate, tnrz, rnrz} = 10'h000;
    {res, tes, one_clk} = 3'h0;
    {fr_d, fr_s, fr_fs, ts_d, ts_s, fl_bit} = 6'h00;
    run = 1'h1;
    void'($urandom(48));
    repeat (3) @(posedge clk);
    check(pin_oe, 1'h1);
    check(tl_dat, 1'h0);
    check(rs_d, 1'h0);
    #2;
    rst_n = 1'h1;
    foreach (fixed_cfg[i])
      scen({3'h0, fixed_cfg[i]});
    repeat (4)
      scen({3'h0, 10'($urandom) & 10'h337});
    scen(13'h060B); // reference clock drives both directions
    scen(13'h1B03); // both stores on, t1 rate
    scen(13'h1B07); // both stores on, e1 rate
    end_sim();
  end
endmodule
